/* logic/asr_pkg.sv */
// Package for the asynchronous SRAM host controller.
// Assumes a 100 MHz system clock; pin timing derived from ns figures here.
package asr_pkg;
	localparam int ASR_ADDR_W          = 18;
	localparam int ASR_DATA_W          = 32;
	localparam int ASR_HALF_W          = 16;
	localparam int ASR_CLK_PERIOD_NS   = 10;
	// Minimum times, ns
	localparam int ASR_ADDR_ACCESS_NS  = 25;
	localparam int ASR_SEL_ACCESS_NS   = 25;
	localparam int ASR_DRV_ACCESS_NS   = 10;
	localparam int ASR_READ_CYCLE_NS   = 25;
	localparam int ASR_FLOAT_NS        = 10;
	localparam int ASR_WR_PULSE_NS     = 20;
	localparam int ASR_ADDR_SETUP_NS   = 5;
	localparam int ASR_HOLD_NS         = 5;
	// Cycle counts, rounded up, at least one
	localparam int ASR_READ_CYC  = (ASR_SEL_ACCESS_NS + ASR_ADDR_SETUP_NS + ASR_CLK_PERIOD_NS - 1)
		/ ASR_CLK_PERIOD_NS;
	localparam int ASR_RCYC_CYC  = (ASR_READ_CYCLE_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
	localparam int ASR_FLOAT_CYC = (ASR_FLOAT_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
	localparam int ASR_WPUL_CYC  = (ASR_WR_PULSE_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
	localparam int ASR_SETUP_CYC = (ASR_ADDR_SETUP_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
	localparam int ASR_HOLD_CYC  = (ASR_HOLD_NS + ASR_CLK_PERIOD_NS - 1) / ASR_CLK_PERIOD_NS;
	// Extra wait for read data to pass the pin synchroniser
	localparam int ASR_SYNC_CYC  = 2;
	localparam int ASR_CNT_W     = 4;
	typedef enum logic {ASR_WR_STROBE, ASR_WR_SELECT} asr_wmode_t;
endpackage

/* logic/asr_tmr_if.sv */
// Interface between the controller FSM and its delay counter.
// Assumes one clock domain shared by both ends.
interface asr_tmr_if;
	import asr_pkg::*;
	logic                 load;
	logic [ASR_CNT_W-1:0] count;
	logic                 done;
	modport ctl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

/* logic/asr_timer.sv */
// Loadable down counter timing pin phases.
// Assumes loads come from the controller on the same clock.
module asr_timer
	import asr_pkg::*;
(
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_reset,
	// Control
	asr_tmr_if.tmr    t
);
	logic [ASR_CNT_W-1:0] cnt_reg;
	logic [ASR_CNT_W-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (t.load) begin
			cnt_next = t.count;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 4'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// Done must not depend on load: the controller loads on done
	assign t.done = (cnt_reg == '0);
endmodule

/* logic/asr_ctrl.sv */
// Host controller driving an asynchronous 256K x 32 SRAM over its pins.
// Assumes the SRAM sits on the pins below; DQ level resolved outside.
// Function
// [R01] Memory is 262144 words of 32 bits
// [R02] Device unclocked; pins alone time access
// [R03] Select high means standby, bus floats
// [R04] Strobe high read, strobe low write
// [R05] Output drive ignored during writes
// [R06] Data floats if drive high or strobe low
// [R07] Read drives only selected halves
// [R08] Write stores only selected halves
// [R09] Both halves deselected: no write, float
// [R10] Each address change starts new read
// [R11] Address changes no faster than read cycle
// [R12] Select read: address stable, drive on
// [R13] Data valid after latest access delay
// [R14] Strobe write ends on strobe rise
// [R15] Select write ends on select rise
// [R16] Wait float time before driving write data
// [R17] Reads return last written half-words
module asr_ctrl
	import asr_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_reset,
	// User request
	input  wire logic                  i_req,
	input  wire logic                  i_write,
	input  wire logic                  i_sel_mode,
	input  wire logic [1:0]            i_half_en,
	input  wire logic [ASR_ADDR_W-1:0] i_addr,
	input  wire logic [ASR_DATA_W-1:0] i_wdata,
	output logic                       o_ready,
	output logic                       o_rvalid,
	output logic [ASR_DATA_W-1:0]      o_rdata,
	// Memory pins
	output logic [ASR_ADDR_W-1:0]      o_addr,
	output logic                       o_chip_select_n,
	output logic                       o_write_strobe_n,
	output logic                       o_output_drive_n,
	output logic                       o_lower_half_select_n,
	output logic                       o_upper_half_select_n,
	input  wire logic [ASR_DATA_W-1:0] i_dq,
	output logic [ASR_DATA_W-1:0]      o_dq,
	output logic [1:0]                 o_dq_oe_n
);
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_RWAIT, S_FLOAT, S_WPULSE, S_HOLD, S_GAP} asr_state_t;

	asr_tmr_if tif ();
	asr_timer u_timer (
		.i_mclk  (i_mclk),
		.i_reset (i_reset),
		.t       (tif)
	);

	asr_state_t            st_reg, st_next;
	logic                  wr_reg, wr_next;
	asr_wmode_t            wm_reg, wm_next;
	logic [ASR_ADDR_W-1:0] a_reg, a_next;
	logic [ASR_DATA_W-1:0] wd_reg, wd_next;
	logic [ASR_DATA_W-1:0] rd_reg, rd_next;
	logic                  cs_reg, cs_next;
	logic                  we_reg, we_next;
	logic                  oe_reg, oe_next;
	logic                  lo_reg, lo_next;
	logic                  hi_reg, hi_next;
	logic [1:0]            doe_reg, doe_next;
	logic                  rdy_reg, rdy_next;
	logic                  rv_reg, rv_next;
	logic [ASR_DATA_W-1:0] dq_s1, dq_s2, dq_s3;

	// Read data sampled through three stages; the memory is unclocked
	always_ff @(posedge i_mclk) begin
		dq_s1 <= i_dq; // [R02]
		dq_s2 <= dq_s1;
		dq_s3 <= dq_s2;
	end

	always_comb begin
		st_next  = st_reg;
		wr_next  = wr_reg;
		wm_next  = wm_reg;
		a_next   = a_reg;
		wd_next  = wd_reg;
		rd_next  = rd_reg;
		cs_next  = cs_reg;
		we_next  = we_reg;
		oe_next  = oe_reg;
		lo_next  = lo_reg;
		hi_next  = hi_reg;
		doe_next = doe_reg;
		rdy_next = 1'b0;
		rv_next  = 1'b0;
		tif.load  = 1'b0;
		tif.count = '0;
		case (st_reg)
			S_IDLE: begin
				rdy_next = 1'b1;
				if (i_req && rdy_reg) begin
					rdy_next = 1'b0;
					wr_next  = i_write;
					wm_next  = i_sel_mode ? ASR_WR_SELECT : ASR_WR_STROBE;
					a_next   = i_addr; // [R01] [R12]
					wd_next  = i_wdata;
					lo_next  = ~i_half_en[0]; // [R07] [R08] [R09]
					hi_next  = ~i_half_en[1];
					oe_next  = i_write; // [R05]
					we_next  = 1'b1;
					cs_next  = 1'b1; // [R03]
					tif.load  = 1'b1;
					tif.count = ASR_CNT_W'(ASR_SETUP_CYC);
					st_next  = S_SETUP;
				end
			end
			S_SETUP: begin
				if (tif.done) begin
					cs_next = 1'b0;
					if (wr_reg) begin
						we_next   = 1'b0; // [R04]
						tif.load  = 1'b1;
						tif.count = ASR_CNT_W'(ASR_FLOAT_CYC);
						st_next   = S_FLOAT;
					end else begin
						tif.load  = 1'b1;
						tif.count = ASR_CNT_W'(ASR_READ_CYC + ASR_SYNC_CYC); // [R13]
						st_next   = S_RWAIT;
					end
				end
			end
			S_RWAIT: begin
				if (tif.done) begin
					rd_next  = dq_s3; // [R17]
					rv_next  = 1'b1;
					cs_next  = 1'b1;
					oe_next  = 1'b1;
					tif.load  = 1'b1;
					tif.count = ASR_CNT_W'(ASR_RCYC_CYC); // [R11]
					st_next  = S_GAP;
				end
			end
			S_FLOAT: begin
				if (tif.done) begin
					doe_next  = {hi_reg, lo_reg}; // [R16]
					tif.load  = 1'b1;
					tif.count = ASR_CNT_W'(ASR_WPUL_CYC);
					st_next   = S_WPULSE;
				end
			end
			S_WPULSE: begin
				if (tif.done) begin
					if (wm_reg == ASR_WR_STROBE) begin
						we_next = 1'b1; // [R14]
					end else begin
						cs_next = 1'b1; // [R15]
					end
					tif.load  = 1'b1;
					tif.count = ASR_CNT_W'(ASR_HOLD_CYC);
					st_next   = S_HOLD;
				end
			end
			S_HOLD: begin
				if (tif.done) begin
					doe_next  = 2'h3;
					cs_next   = 1'b1;
					we_next   = 1'b1;
					tif.load  = 1'b1;
					tif.count = ASR_CNT_W'(ASR_RCYC_CYC);
					st_next   = S_GAP;
				end
			end
			S_GAP: begin
				if (tif.done) begin
					rdy_next = 1'b1;
					st_next  = S_IDLE;
				end
			end
			default: begin
				st_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st_reg  <= S_IDLE;
			wr_reg  <= 1'b0;
			wm_reg  <= ASR_WR_STROBE;
			a_reg   <= '0;
			wd_reg  <= '0;
			rd_reg  <= '0;
			cs_reg  <= 1'b1;
			we_reg  <= 1'b1;
			oe_reg  <= 1'b1;
			lo_reg  <= 1'b1;
			hi_reg  <= 1'b1;
			doe_reg <= 2'h3;
			rdy_reg <= 1'b0;
			rv_reg  <= 1'b0;
		end else begin
			st_reg  <= st_next;
			wr_reg  <= wr_next;
			wm_reg  <= wm_next;
			a_reg   <= a_next;
			wd_reg  <= wd_next;
			rd_reg  <= rd_next;
			cs_reg  <= cs_next;
			we_reg  <= we_next;
			oe_reg  <= oe_next;
			lo_reg  <= lo_next;
			hi_reg  <= hi_next;
			doe_reg <= doe_next;
			rdy_reg <= rdy_next;
			rv_reg  <= rv_next;
		end
	end

	assign o_ready               = rdy_reg;
	assign o_rvalid              = rv_reg;
	assign o_rdata               = rd_reg;
	assign o_addr                = a_reg;
	assign o_chip_select_n       = cs_reg;
	assign o_write_strobe_n      = we_reg;
	assign o_output_drive_n      = oe_reg;
	assign o_lower_half_select_n = lo_reg;
	assign o_upper_half_select_n = hi_reg;
	assign o_dq                  = wd_reg;
	assign o_dq_oe_n             = doe_reg;

	sequence s_strobe_fall;
		$fell(we_reg) && !cs_reg;
	endsequence

	a_float_before_drive: assert property (@(posedge i_mclk) disable iff (i_reset) // [R16]
		s_strobe_fall |-> doe_reg == 2'h3 [*1] ##1 (doe_reg == 2'h3))
		else $error("write data driven before float time");
	a_drive_only_write: assert property (@(posedge i_mclk) disable iff (i_reset) // [R06]
		(doe_reg != 2'h3) |-> (!we_reg || !cs_reg || st_reg == S_HOLD))
		else $error("host drives bus outside write");
	a_addr_stable_read: assert property (@(posedge i_mclk) disable iff (i_reset) // [R12]
		(!cs_reg && we_reg && st_reg == S_RWAIT) |=> $stable(a_reg))
		else $error("address moved during read");
	a_read_oe_low: assert property (@(posedge i_mclk) disable iff (i_reset) // [R12]
		(st_reg == S_RWAIT) |-> !oe_reg && we_reg)
		else $error("read without output drive");
	a_read_wait_len: assert property (@(posedge i_mclk) disable iff (i_reset) // [R13]
		($fell(cs_reg) && we_reg) |-> !rv_reg [*3])
		else $error("read data taken too early");
	a_wr_pulse_len: assert property (@(posedge i_mclk) disable iff (i_reset) // [R14]
		$rose(st_reg == S_WPULSE) |-> (!we_reg && !cs_reg) [*2])
		else $error("write pulse too short");
	a_sel_end: assert property (@(posedge i_mclk) disable iff (i_reset) // [R15]
		(st_reg == S_HOLD && wm_reg == ASR_WR_SELECT) |-> cs_reg)
		else $error("select write not ended by select");
	a_halves_match: assert property (@(posedge i_mclk) disable iff (i_reset) // [R08]
		(doe_reg != 2'h3) |-> doe_reg == {hi_reg, lo_reg})
		else $error("driven halves differ from selects");
	a_gap_spacing: assert property (@(posedge i_mclk) disable iff (i_reset) // [R11]
		$rose(cs_reg) |-> cs_reg [*3])
		else $error("accesses too close");
endmodule

/* verif/asr_sram_model.sv */
// Behavioural asynchronous 256K x 32 SRAM for the host controller bench.
// Assumes the bench resolves the shared DQ wire from both parties' enables.
module asr_sram_model
	import asr_pkg::*;
(
	// Memory pins
	input  wire logic [ASR_ADDR_W-1:0] i_addr,
	input  wire logic                  i_chip_select_n,
	input  wire logic                  i_write_strobe_n,
	input  wire logic                  i_output_drive_n,
	input  wire logic                  i_lower_half_select_n,
	input  wire logic                  i_upper_half_select_n,
	input  wire logic [ASR_DATA_W-1:0] i_dq,
	// Model drive
	output logic [ASR_DATA_W-1:0]      o_dq,
	output logic [1:0]                 o_drv
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [ASR_DATA_W-1:0] mem [0:(1 << ASR_ADDR_W)-1];
	logic                  rd_on;
	logic                  rd_settled;
	logic                  wr_on;
	// Unwritten words read back as their own address
	initial begin
		for (int k = 0; k < (1 << ASR_ADDR_W); k++) begin
			mem[k] = ASR_DATA_W'(k);
		end
	end
	// Levels alone decide, no clock
	assign rd_on = !i_chip_select_n && !i_output_drive_n && i_write_strobe_n;
	assign wr_on = !i_chip_select_n && !i_write_strobe_n;
	assign o_drv = {rd_on && !i_upper_half_select_n, rd_on && !i_lower_half_select_n};
	// Lanes turn on at once but show the inverted word until access time passes
	assign #(ASR_SEL_ACCESS_NS) rd_settled = rd_on;
	assign o_dq = rd_settled ? mem[i_addr] : ~mem[i_addr];
	// Write lands when strobe or select ends it
	always @(negedge wr_on) begin
		logic [ASR_DATA_W-1:0] w;
		w = mem[i_addr];
		if (!i_lower_half_select_n) w[15:0] = i_dq[15:0];
		if (!i_upper_half_select_n) w[31:16] = i_dq[31:16];
		mem[i_addr] = w;
	end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the asynchronous SRAM host controller.
// Assumes the behavioural SRAM model stands on the memory pins.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk = 1'b0;
	logic        i_reset = 1'b1;
	logic        req = 1'b0;
	logic        wr = 1'b0;
	logic        sm = 1'b0;
	logic [1:0]  he = 2'h0;
	logic [17:0] a = 18'h0;
	logic [31:0] d = 32'h0;
	logic        rdy, rv, cs, we, oe, lo, hi;
	logic [17:0] pa;
	logic [31:0] rd, hq, mq;
	wire  [31:0] dq;
	logic [31:0] flt = 32'h5A5AA5A5;
	logic [1:0]  hoe, mdrv;
	int          err_count = 0;
	int          comparisons = 0;
	always #5 i_mclk = ~i_mclk;
	// Undriven lanes toggle so stale data never passes
	always @(posedge i_mclk) flt <= ~flt;
	assign dq[15:0]  = !hoe[0] ? hq[15:0] : mdrv[0] ? mq[15:0] : flt[15:0];
	assign dq[31:16] = !hoe[1] ? hq[31:16] : mdrv[1] ? mq[31:16] : flt[31:16];
	asr_ctrl u_asr_ctrl (.i_mclk(i_mclk), .i_reset(i_reset), .i_req(req), .i_write(wr), .i_sel_mode(sm),
		.i_half_en(he), .i_addr(a), .i_wdata(d), .o_ready(rdy), .o_rvalid(rv), .o_rdata(rd), .o_addr(pa),
		.o_chip_select_n(cs), .o_write_strobe_n(we), .o_output_drive_n(oe), .o_lower_half_select_n(lo),
		.o_upper_half_select_n(hi), .i_dq(dq), .o_dq(hq), .o_dq_oe_n(hoe));
	asr_sram_model u_asr_sram_model (.i_addr(pa), .i_chip_select_n(cs), .i_write_strobe_n(we),
		.i_output_drive_n(oe), .i_lower_half_select_n(lo), .i_upper_half_select_n(hi), .i_dq(dq),
		.o_dq(mq), .o_drv(mdrv));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic bail();
		err_count++;
		conclude();
	endtask
	// No lane driven by both parties at once
	always @(negedge i_mclk) if (!i_reset) chk({30'h0, ~hoe & mdrv}, 32'h0);
	task automatic op(input logic w, input logic s, input logic [1:0] h, input logic [17:0] ad,
		input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		q = 32'h0;
		do begin
			@(negedge i_mclk);
			n++;
			if (n > 50) bail();
		end while (rdy !== 1'b1);
		@(posedge i_mclk);
		req <= 1'b1;
		wr <= w;
		sm <= s;
		he <= h;
		a <= ad;
		d <= wd;
		@(posedge i_mclk);
		req <= 1'b0;
		if (!w) begin
			n = 0;
			do begin
				@(negedge i_mclk);
				n++;
				if (n > 50) bail();
			end while (rv !== 1'b1);
			q = rd;
		end
	endtask
	task automatic t_reset();
		chk({27'h0, cs, we, oe, lo, hi}, 32'h1F);
		chk({30'h0, hoe}, 32'h3);
		$display("test reset done");
	endtask
	task automatic t_word();
		logic [31:0] q;
		for (int s = 0; s < 2; s++) begin
			op(1'b1, s[0], 2'h3, 18'(18'h3FFFF - s), 32'(32'hC0DE0000 + s), q);
			op(1'b0, 1'b0, 2'h3, 18'(18'h3FFFF - s), 32'h0, q);
			chk(q, 32'(32'hC0DE0000 + s));
		end
		op(1'b0, 1'b0, 2'h3, 18'h12345, 32'h0, q);
		chk(q, 32'h00012345);
		$display("test word done");
	endtask
	task automatic t_half();
		logic [31:0] q;
		op(1'b1, 1'b0, 2'h3, 18'h5, 32'h11112222, q);
		op(1'b1, 1'b0, 2'h1, 18'h5, 32'hAAAABBBB, q);
		op(1'b1, 1'b1, 2'h2, 18'h5, 32'hCCCCDDDD, q);
		op(1'b1, 1'b0, 2'h0, 18'h5, 32'h00000000, q);
		op(1'b0, 1'b0, 2'h1, 18'h5, 32'h0, q);
		chk({16'h0, q[15:0]}, 32'h0000BBBB);
		op(1'b0, 1'b0, 2'h2, 18'h5, 32'h0, q);
		chk({q[31:16], 16'h0}, 32'hCCCC0000);
		op(1'b0, 1'b0, 2'h3, 18'h5, 32'h0, q);
		chk(q, 32'hCCCCBBBB);
		$display("test half done");
	endtask
	initial begin
		@(negedge i_mclk);
		t_reset();
		repeat (2) @(posedge i_mclk);
		i_reset <= 1'b0;
		t_word();
		t_half();
		conclude();
	end
endmodule
